// File: verilog/cpw_top.sv
// Complementary PWM phase generator with three-stage duty path and register port
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpw_regs.svh"
module cpw_top #(
  parameter int CW = 16,
  parameter int TICK_DIV = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`CPW_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic pos_phase,
  output logic neg_phase
);
  // Software-visible registers
  logic [CW-1:0] duty_buffer_reg_r, duty_buffer_reg_nxt;
  logic [CW-1:0] carrier_cycle_reg_r, carrier_cycle_reg_nxt;
  logic [CW-1:0] half_period_value_r, half_period_value_nxt;
  logic [CW-1:0] dead_time_value_r, dead_time_value_nxt;
  logic run_r, run_nxt;
  cpw_pkg::cpw_mode_type mode_r, mode_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Duty path and counter
  logic [CW-1:0] duty_temp_reg_r, duty_temp_reg_nxt;
  logic [CW-1:0] duty_compare_reg_r, duty_compare_reg_nxt;
  logic buf_pend_r, buf_pend_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic up_r, up_nxt;
  logic [15:0] div_r, div_nxt;
  logic tick;
  // Phase state
  logic pos_raw_r, pos_raw_nxt;
  logic off_seen_r, off_seen_nxt;
  logic crest, trough, on_match, off_match, cmp_hit, tmp_match;
  logic dt_pos, dt_neg;

  // Field extraction shared by several register writes
  function automatic logic [CW-1:0] low_field(input logic [31:0] d);
    low_field = d[CW-1:0];
  endfunction

  // Register writes and read data; read data stands only in the following cycle
  always_comb
  begin
    duty_buffer_reg_nxt = duty_buffer_reg_r;
    carrier_cycle_reg_nxt = carrier_cycle_reg_r;
    half_period_value_nxt = half_period_value_r;
    dead_time_value_nxt = dead_time_value_r;
    run_nxt = run_r;
    mode_nxt = mode_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr)
    begin
      case (reg_addr)
        `CPW_OFF_DUTY_BUF: duty_buffer_reg_nxt = low_field(reg_wdata);
        `CPW_OFF_CYCLE: carrier_cycle_reg_nxt = low_field(reg_wdata);
        `CPW_OFF_HALF: half_period_value_nxt = low_field(reg_wdata);
        `CPW_OFF_DEAD: dead_time_value_nxt = low_field(reg_wdata);
        `CPW_OFF_CTRL:
        begin
          run_nxt = reg_wdata[`CPW_CTRL_RUN];
          mode_nxt = reg_wdata[`CPW_CTRL_MODE3] ? cpw_pkg::CPW_MODE3 : cpw_pkg::CPW_MODE2;
        end
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `CPW_OFF_DUTY_BUF: rdata_nxt[CW-1:0] = duty_buffer_reg_r;
        `CPW_OFF_CYCLE: rdata_nxt[CW-1:0] = carrier_cycle_reg_r;
        `CPW_OFF_HALF: rdata_nxt[CW-1:0] = half_period_value_r;
        `CPW_OFF_DEAD: rdata_nxt[CW-1:0] = dead_time_value_r;
        `CPW_OFF_CTRL:
        begin
          rdata_nxt[`CPW_CTRL_RUN] = run_r;
          rdata_nxt[`CPW_CTRL_MODE3] = (mode_r == cpw_pkg::CPW_MODE3);
        end
        `CPW_OFF_STATUS:
        begin
          rdata_nxt[`CPW_ST_UP] = up_r;
          rdata_nxt[`CPW_ST_POS] = dt_pos;
          rdata_nxt[`CPW_ST_NEG] = dt_neg;
          rdata_nxt[`CPW_ST_OFFSEEN] = off_seen_r;
          rdata_nxt[`CPW_ST_CNT_LSB +: CW] = cnt_r;
        end
        `CPW_OFF_TEMP: rdata_nxt[CW-1:0] = duty_temp_reg_r;
        `CPW_OFF_CMP: rdata_nxt[CW-1:0] = duty_compare_reg_r;
        default: rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
      endcase
    end
  end

  // Register group flip-flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      duty_buffer_reg_r <= `CPW_RST_DUTY;
      carrier_cycle_reg_r <= `CPW_RST_CYCLE;
      half_period_value_r <= `CPW_RST_HALF;
      dead_time_value_r <= `CPW_RST_DEAD;
      run_r <= 1'b0;
      mode_r <= cpw_pkg::CPW_MODE2;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      duty_buffer_reg_r <= duty_buffer_reg_nxt;
      carrier_cycle_reg_r <= carrier_cycle_reg_nxt;
      half_period_value_r <= half_period_value_nxt;
      dead_time_value_r <= dead_time_value_nxt;
      run_r <= run_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Timer clock enable, triangle counter and duty transfers
  assign tick = run_r && (div_r == 16'(TICK_DIV - 1));
  assign crest = up_r && (cnt_r >= carrier_cycle_reg_r);
  assign trough = !up_r && (cnt_r == `CPW_CNT_ZERO);
  always_comb
  begin
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    duty_temp_reg_nxt = duty_temp_reg_r;
    duty_compare_reg_nxt = duty_compare_reg_r;
    buf_pend_nxt = buf_pend_r || (reg_wr && reg_addr == `CPW_OFF_DUTY_BUF);
    if (run_r)
    begin
      div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    end
    if (tick)
    begin
      // Buffer moves to temporary on the next timer tick, whenever written
      if (buf_pend_r)
      begin
        duty_temp_reg_nxt = duty_buffer_reg_r;
        buf_pend_nxt = reg_wr && reg_addr == `CPW_OFF_DUTY_BUF;
      end
      // Mode 2 loads compare at crest only; mode 3 at crest and trough
      if (crest || (trough && mode_r == cpw_pkg::CPW_MODE3))
      begin
        duty_compare_reg_nxt = duty_temp_reg_r;
      end
      if (crest)
      begin
        up_nxt = 1'b0;
        cnt_nxt = cnt_r - `CPW_CNT_ONE;
      end
      else if (trough)
      begin
        up_nxt = 1'b1;
        cnt_nxt = cnt_r + `CPW_CNT_ONE;
      end
      else
      begin
        cnt_nxt = up_r ? cnt_r + `CPW_CNT_ONE : cnt_r - `CPW_CNT_ONE;
      end
    end
  end

  // Counter group flip-flops; output starts at the trough
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_r <= 16'h0000;
      cnt_r <= `CPW_CNT_ZERO;
      up_r <= 1'b1;
      duty_temp_reg_r <= `CPW_RST_DUTY;
      duty_compare_reg_r <= `CPW_RST_DUTY;
      buf_pend_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      duty_temp_reg_r <= duty_temp_reg_nxt;
      duty_compare_reg_r <= duty_compare_reg_nxt;
      buf_pend_r <= buf_pend_nxt;
    end
  end

  // Match events: a rising match switches on, a falling one off; at the crest both meet
  assign cmp_hit = tick && (cnt_r == duty_compare_reg_r);
  assign on_match = cmp_hit && !crest && (up_r || trough);
  assign off_match = cmp_hit && !crest && !up_r && !trough;
  // Temporary match acts only while the new duty lengthens the off time; the near-full side is not covered
  assign tmp_match = tick && (cnt_r == duty_temp_reg_r) && (duty_temp_reg_r > duty_compare_reg_r);

  // Positive phase decision; the off-seen latch lives until the next trough
  always_comb
  begin
    pos_raw_nxt = pos_raw_r;
    off_seen_nxt = off_seen_r;
    if (tick && trough)
    begin
      off_seen_nxt = 1'b0;
    end
    if (cmp_hit && crest)
    begin
      // On and off meet at the crest, so the cycle value holds a steady 0%
      pos_raw_nxt = pos_raw_r;
    end
    else if (tmp_match)
    begin
      // Off on an already-off phase is a no-op, never a toggle; the set beats the trough clear
      pos_raw_nxt = 1'b0;
      off_seen_nxt = 1'b1;
    end
    else if (off_match)
    begin
      pos_raw_nxt = 1'b0;
    end
    else if (on_match && !off_seen_r)
    begin
      pos_raw_nxt = 1'b1;
    end
    else if (on_match)
    begin
      pos_raw_nxt = 1'b0;
    end
  end

  // Phase group flip-flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pos_raw_r <= 1'b0;
      off_seen_r <= 1'b0;
    end
    else
    begin
      pos_raw_r <= pos_raw_nxt;
      off_seen_r <= off_seen_nxt;
    end
  end

  // Dead-time stage drives both pins from its own flip-flops
  cpw_dead_time #(
    .CW(CW)
  ) u_dead (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .pos_raw(pos_raw_r),
    .dead_cnt(dead_time_value_r),
    .pos_out(dt_pos),
    .neg_out(dt_neg)
  );

  assign pos_phase = dt_pos;
  assign neg_phase = dt_neg;
  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// File: verilog/cpw_regs.svh
// Register offsets, field positions and reset values of the complementary PWM block
`ifndef CPW_REGS_SVH
`define CPW_REGS_SVH
`define CPW_ADDR_W 8
`define CPW_OFF_DUTY_BUF 8'h00
`define CPW_OFF_CYCLE 8'h04
`define CPW_OFF_HALF 8'h08
`define CPW_OFF_DEAD 8'h0C
`define CPW_OFF_CTRL 8'h10
`define CPW_OFF_STATUS 8'h14
`define CPW_OFF_TEMP 8'h18
`define CPW_OFF_CMP 8'h1C
`define CPW_CTRL_RUN 0
`define CPW_CTRL_MODE3 1
`define CPW_ST_UP 0
`define CPW_ST_POS 1
`define CPW_ST_NEG 2
`define CPW_ST_OFFSEEN 3
`define CPW_ST_CNT_LSB 16
`define CPW_RST_CYCLE 16'h0100
`define CPW_RST_HALF 16'h0080
`define CPW_RST_DEAD 16'h0008
`define CPW_RST_DUTY 16'h0100
`define CPW_CNT_ZERO 16'h0000
`define CPW_CNT_ONE 16'h0001
`endif

// File: verilog/cpw_pkg.sv
// Types shared by the complementary PWM block
package cpw_pkg;
  typedef enum logic {CPW_MODE2, CPW_MODE3} cpw_mode_type;
  typedef enum logic [1:0] {CPW_DT_IDLE, CPW_DT_WAIT} cpw_dt_state_type;
endpackage

// File: verilog/cpw_dead_time.sv
// Dead-time inserter producing complementary positive and negative phase outputs
`timescale 1ns/1ps
`default_nettype none
`include "cpw_regs.svh"
module cpw_dead_time #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic pos_raw,
  input wire logic [CW-1:0] dead_cnt,
  output logic pos_out,
  output logic neg_out
);
  cpw_pkg::cpw_dt_state_type st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic tgt_r, tgt_nxt;
  logic pos_r, pos_nxt, neg_r, neg_nxt;

  // Any change of the raw phase blanks both outputs for the dead count first
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tgt_nxt = tgt_r;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    case (st_r)
      cpw_pkg::CPW_DT_IDLE:
      begin
        if (pos_raw != tgt_r)
        begin
          tgt_nxt = pos_raw;
          pos_nxt = 1'b0;
          neg_nxt = 1'b0;
          cnt_nxt = dead_cnt;
          st_nxt = cpw_pkg::CPW_DT_WAIT;
        end
      end
      cpw_pkg::CPW_DT_WAIT:
      begin
        if (pos_raw != tgt_r)
        begin
          // A reversal inside the gap restarts it rather than shortening it
          tgt_nxt = pos_raw;
          cnt_nxt = dead_cnt;
        end
        else if (cnt_r == `CPW_CNT_ZERO)
        begin
          pos_nxt = tgt_r;
          neg_nxt = ~tgt_r;
          st_nxt = cpw_pkg::CPW_DT_IDLE;
        end
        else if (tick)
        begin
          cnt_nxt = cnt_r - `CPW_CNT_ONE;
        end
      end
      default:
      begin
        st_nxt = cpw_pkg::CPW_DT_IDLE;
      end
    endcase
  end

  // State registers; after reset positive is off and negative on
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= cpw_pkg::CPW_DT_IDLE;
      cnt_r <= '0;
      tgt_r <= 1'b0;
      pos_r <= 1'b0;
      neg_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tgt_r <= tgt_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
    end
  end

  assign pos_out = pos_r;
  assign neg_out = neg_r;
endmodule
`default_nettype wire

// File: verification/cpw_gate_model.sv
// Gate driver model that totals on-time of both switches and flags shoot-through
`timescale 1ns/1ps
`default_nettype none
module cpw_gate_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic pos_phase,
  input wire logic neg_phase,
  output logic [15:0] pos_on,
  output logic [15:0] neg_on,
  output logic shoot
);
  // On-time totals; the flag latches, since one overlap cycle would already destroy the leg
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset || clear)
    begin
      pos_on <= 16'h0000;
      neg_on <= 16'h0000;
      shoot <= 1'b0;
    end
    else
    begin
      pos_on <= pos_on + {15'h0000, pos_phase};
      neg_on <= neg_on + {15'h0000, neg_phase};
      shoot <= shoot | (pos_phase & neg_phase);
    end
  end
endmodule
`default_nettype wire

// File: verification/cpw_top_properties.sv
// Port checks of the complementary PWM block
`timescale 1ns/1ps
`default_nettype none
`include "cpw_regs.svh"
module cpw_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`CPW_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pos_phase,
  input wire logic neg_phase
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_NO_OVERLAP: assert property (!(pos_phase && neg_phase)) else $error("both phases on");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data out of slot");
  AST_UPPER_ZERO: assert property ($past(reg_rd) && $past(reg_addr) != `CPW_OFF_STATUS |-> reg_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) > `CPW_OFF_CMP |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_POS_GAP: assert property ($rose(pos_phase) |-> !$past(neg_phase, 1) && !$past(neg_phase, 2))
    else $error("positive on without gap");
  AST_NEG_GAP: assert property ($rose(neg_phase) |-> !$past(pos_phase, 1) && !$past(pos_phase, 2))
    else $error("negative on without gap");
  AST_POS_OFF_GAP: assert property ($fell(pos_phase) |=> !neg_phase [*2]) else $error("negative follows too soon");
  AST_NEG_OFF_GAP: assert property ($fell(neg_phase) |=> !pos_phase [*2]) else $error("positive follows too soon");
endmodule
bind cpw_top cpw_checker cpw_checker_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pos_phase(pos_phase), .neg_phase(neg_phase));
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the complementary PWM block
`timescale 1ns/1ps
`default_nettype none
`include "cpw_regs.svh"
module testbench;
  localparam int CYC = 32;
  localparam int DEAD = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [`CPW_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clear = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic pos_phase;
  logic neg_phase;
  logic [15:0] pos_on;
  logic [15:0] neg_on;
  logic shoot;
  int mismatches = 0;
  int tests_run = 0;
  cpw_top cpw_top_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_phase(pos_phase), .neg_phase(neg_phase));
  cpw_gate_model cpw_gate_model_inst (.clk(clk), .reset(reset), .clear(clear), .pos_phase(pos_phase),
    .neg_phase(neg_phase), .pos_on(pos_on), .neg_on(neg_on), .shoot(shoot));
  initial forever #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  // Four whole carrier periods, so the result does not hang on the start phase
  task automatic measure(input int pexp, input int nexp);
    repeat (6 * CYC) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (8 * CYC) @(posedge clk);
    #1;
    check({16'h0000, pos_on}, pexp[31:0]);
    check({16'h0000, neg_on}, nexp[31:0]);
    check({31'h0, shoot}, 32'h0000_0000);
  endtask
  task automatic test_regs;
    // Control reads idle and status reads counting up, positive off, negative on
    logic [7:0] addrs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h10, 8'h14};
    logic [31:0] vals [9] = '{32'h0000_0100, 32'h0000_0100, 32'h0000_0080, 32'h0000_0008, 32'h0000_0100,
      32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_0005};
    check({30'h0, pos_phase, neg_phase}, 32'h0000_0001);
    for (int i = 0; i < 9; i++)
    begin
      rd(addrs[i]);
      check(rd_val, vals[i]);
    end
    wr(`CPW_OFF_CMP, 32'h0000_1234);
    rd(`CPW_OFF_CMP);
    check(rd_val, 32'h0000_0100);
    wr(`CPW_OFF_CYCLE, CYC);
    rd(`CPW_OFF_CYCLE);
    check(rd_val, CYC);
  endtask
  // New duty taken at a chosen skew into the carrier, so either interval can receive the write
  task automatic test_duty(input logic mode3, input int d, input int skew);
    repeat (skew) @(posedge clk);
    wr(`CPW_OFF_DUTY_BUF, d);
    wr(`CPW_OFF_CTRL, {30'h0, mode3, 1'b1});
    if (d == 0)
      measure(8 * CYC, 0);
    else if (d == CYC)
      measure(0, 8 * CYC);
    else
      measure(4 * (2 * (CYC - d) - DEAD - 1), 4 * (2 * d - DEAD - 1));
  endtask
  task automatic test_stages;
    wr(`CPW_OFF_DUTY_BUF, 32'h0000_0018);
    repeat (4 * CYC) @(posedge clk);
    rd(`CPW_OFF_TEMP);
    check(rd_val, 32'h0000_0018);
    rd(`CPW_OFF_CMP);
    check(rd_val, 32'h0000_0018);
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Nine duty scenarios of fourteen carrier halves each, fifteen with a skew of 32, with generous margin
  initial
  begin
    repeat (20 * 14 * CYC) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    test_regs();
    test_duty(1'b0, 16, 0);
    test_duty(1'b0, CYC, 0);
    test_duty(1'b0, 16, 0);
    test_duty(1'b0, 16, 32);
    test_duty(1'b0, 0, 0);
    test_duty(1'b1, 16, 0);
    test_duty(1'b1, CYC, 32);
    test_duty(1'b1, 20, 32);
    test_duty(1'b1, 0, 0);
    test_stages();
    end_of_test();
  end
endmodule
`default_nettype wire
